// file: src/ptsr_regs.sv
// Low threshold, pin function, power and status registers of the proximity converter.
//
// Overview of operation
// RQ1: Writing the low LSB location only fills a buffer; active threshold unchanged.
// RQ2: Reading the low LSB location returns active threshold bits 7:0.
// RQ3: Writing the low MSB location commits it with the buffered LSB at once.
// RQ4: Reading the low MSB location returns active threshold bits 15:8.
// RQ5: Host writes the low LSB location first, then the MSB location.
// RQ6: Pin mode 100 drives the interrupt output as active-low data ready.
// RQ7: Pin mode 010 makes the interrupt output follow the comparator flag.
// RQ8: Pin mode 001 makes the interrupt output signal the wake-up event.
// RQ9: Pin mode 000 disables every pin function; other codes are reserved.
// RQ10: Power bit 0 selects standby when 0, active conversions when 1; resets 0.
// RQ11: Status bit 7 reads 1 when the oscillator is overloaded and stopped.
// RQ12: Status bit 6 reads 0 when a new result waits, else 1.
// RQ13: Status bit 5 reads 0 after a wake-up trigger, 1 when wake-up disabled.
// RQ14: Status bit 4 reads 0 above high threshold, 1 below low threshold.
// RQ15: Status and result LSB are read-only; writes to them do nothing.
// RQ16: A read of the result LSB location moves the pending result into view.
// RQ17: High threshold is updated by the same LSB-then-MSB buffered scheme.
// RQ18: Between the thresholds the comparator flag keeps its previous value.
`timescale 1ns/1ps
`include "ptsr_map.svh"
module ptsr_regs (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic [7:0]            reg_addr_in,
    input  wire logic                  reg_wr_in,
    input  wire ptsr_pkg::ptsr_byte_t  reg_wdata_in,
    input  wire logic                  reg_rd_in,
    output logic                       reg_rvalid_out,
    output ptsr_pkg::ptsr_byte_t       reg_rdata_out,
    input  wire logic                  result_valid_in,
    input  wire ptsr_pkg::ptsr_word_t  result_prox_in,
    input  wire ptsr_pkg::ptsr_freq_t  result_freq_in,
    input  wire ptsr_pkg::ptsr_word_t  threshold_high_in,
    input  wire logic                  oscillator_stopped_in,
    output ptsr_pkg::ptsr_word_t       threshold_low_out,
    output logic                       conversion_power_select_out,
    output ptsr_pkg::ptsr_word_t       proximity_data_out,
    output ptsr_pkg::ptsr_freq_t       frequency_count_out,
    output logic                       interrupt_out_n
);
    import ptsr_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction

    function automatic ptsr_pin_fn_e decode_pin(input ptsr_mode_t m);
        case (m)
            `PTSR_PIN_MODE_WAKE:  decode_pin = PTSR_PIN_WAKE;
            `PTSR_PIN_MODE_COMP:  decode_pin = PTSR_PIN_COMP;
            `PTSR_PIN_MODE_READY: decode_pin = PTSR_PIN_READY;
            default:              decode_pin = PTSR_PIN_OFF;
        endcase
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    ptsr_byte_t   thr_low_buf_q;
    ptsr_word_t   thr_low_q;
    ptsr_mode_t   pin_mode_q;
    logic         power_q;
    logic         ready_n_q;
    logic         comp_q;
    logic         wake_hit_q;
    logic         osc_fault_q;
    logic         rvalid_q;
    ptsr_byte_t   rdata_q;
    ptsr_byte_t   rdata_d;
    logic         irq_n_q;
    logic         irq_n_d;
    logic         wr_low_lo;
    logic         wr_low_hi;
    logic         wr_pin;
    logic         wr_power;
    logic         rd_result_lo;
    logic         conv_take;
    logic         above_high;
    logic         below_low;
    logic         wake_n;
    ptsr_pin_fn_e pin_fn;
    ptsr_byte_t   status_byte;

    ptsr_snap_if  snap_bus ();

    // ************************************************************
    // Access decode
    // ************************************************************
    // Writes to the status and result locations decode to nothing.
    assign wr_low_lo    = reg_wr_in && addr_is(reg_addr_in, `PTSR_OFS_THR_LOW_LO);
    assign wr_low_hi    = reg_wr_in && addr_is(reg_addr_in, `PTSR_OFS_THR_LOW_HI);
    assign wr_pin       = reg_wr_in && addr_is(reg_addr_in, `PTSR_OFS_PIN_FUNC);
    assign wr_power     = reg_wr_in && addr_is(reg_addr_in, `PTSR_OFS_POWER);
    assign rd_result_lo = reg_rd_in && addr_is(reg_addr_in, `PTSR_OFS_RESULT_LO);

    // ************************************************************
    // Low threshold buffer
    // ************************************************************
    // RQ1: buffer only load
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            thr_low_buf_q <= `PTSR_RST_BYTE;
        end else if (wr_low_lo) begin
            thr_low_buf_q <= reg_wdata_in;
        end
    end

    // ************************************************************
    // Active low threshold
    // ************************************************************
    // RQ3: commit both bytes
    // RQ5: LSB first relied on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            thr_low_q <= `PTSR_RST_THR_LOW;
        end else if (wr_low_hi) begin
            thr_low_q <= {reg_wdata_in, thr_low_buf_q};
        end
    end

    // ************************************************************
    // Pin function
    // ************************************************************
    // RQ9: reserved codes stored
    // Reserved codes are stored as written but act as disabled.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_mode_q <= `PTSR_RST_PIN_MODE;
        end else if (wr_pin) begin
            pin_mode_q <= reg_wdata_in[`PTSR_PIN_MODE_MSB:0];
        end
    end

    assign pin_fn = decode_pin(pin_mode_q);

    // ************************************************************
    // Power setting
    // ************************************************************
    // RQ10: standby or active
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_q <= `PTSR_RST_POWER;
        end else if (wr_power) begin
            power_q <= reg_wdata_in[`PTSR_POWER_BIT];
        end
    end

    // In standby results from the front end are dropped, not queued.
    assign conv_take = result_valid_in && power_q;

    // ************************************************************
    // Comparator
    // ************************************************************
    assign above_high = result_prox_in > threshold_high_in;
    assign below_low  = result_prox_in < thr_low_q;

    // RQ14: above high or below
    // RQ18: hold between thresholds
    // High wins if the thresholds are set crossed over.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comp_q <= `PTSR_RST_COMP;
        end else if (conv_take) begin
            if (above_high) begin
                comp_q <= 1'b0;
            end else if (below_low) begin
                comp_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Wake-up
    // ************************************************************
    // RQ13: wake trigger latch
    // RQ17: high threshold supplied
    // The trigger latches until wake-up mode is left.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_hit_q <= 1'b0;
        end else if (pin_fn != PTSR_PIN_WAKE) begin
            wake_hit_q <= 1'b0;
        end else if (conv_take && above_high) begin
            wake_hit_q <= 1'b1;
        end
    end

    assign wake_n = !((pin_fn == PTSR_PIN_WAKE) && wake_hit_q);

    // ************************************************************
    // Data ready
    // ************************************************************
    // RQ12: ready flag low
    // A result arriving with the read keeps the flag low, so it is not lost.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_n_q <= 1'b1;
        end else if (conv_take) begin
            ready_n_q <= 1'b0;
        end else if (rd_result_lo) begin
            ready_n_q <= 1'b1;
        end
    end

    // ************************************************************
    // Oscillator fault
    // ************************************************************
    // RQ11: oscillator stopped flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_fault_q <= 1'b0;
        end else begin
            osc_fault_q <= oscillator_stopped_in;
        end
    end

    // ************************************************************
    // Conversion snapshot
    // ************************************************************
    assign snap_bus.capture      = conv_take;
    assign snap_bus.capture_prox = result_prox_in;
    assign snap_bus.capture_freq = result_freq_in;
    // RQ16: transfer on read
    assign snap_bus.load         = rd_result_lo;

    ptsr_snapshot u_snapshot (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .snap     (snap_bus.store)
    );

    // ************************************************************
    // Status byte
    // ************************************************************
    always_comb begin
        status_byte = `PTSR_READ_ZERO;
        status_byte[`PTSR_STAT_OSC_BIT]   = osc_fault_q;
        status_byte[`PTSR_STAT_READY_BIT] = ready_n_q;
        status_byte[`PTSR_STAT_WAKE_BIT]  = wake_n;
        status_byte[`PTSR_STAT_COMP_BIT]  = comp_q;
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rdata_d = `PTSR_READ_ZERO;
        case (reg_addr_in)
            // RQ2: active low byte
            `PTSR_OFS_THR_LOW_LO: begin
                rdata_d = thr_low_q[7:0];
            end
            // RQ4: active high byte
            `PTSR_OFS_THR_LOW_HI: begin
                rdata_d = thr_low_q[15:8];
            end
            `PTSR_OFS_PIN_FUNC: begin
                rdata_d[`PTSR_PIN_MODE_MSB:0] = pin_mode_q;
            end
            `PTSR_OFS_POWER: begin
                rdata_d[`PTSR_POWER_BIT] = power_q;
            end
            // RQ15: read only status
            `PTSR_OFS_STATUS: begin
                rdata_d = status_byte;
            end
            // The read that moves the result in already shows the new byte.
            `PTSR_OFS_RESULT_LO: begin
                rdata_d = snap_bus.pend_prox[7:0];
            end
            default: begin
                rdata_d = `PTSR_READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= `PTSR_READ_ZERO;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_in;
        end
    end

    // ************************************************************
    // Interrupt pin
    // ************************************************************
    always_comb begin
        irq_n_d = 1'b1;
        case (pin_fn)
            // RQ6: data ready pin
            PTSR_PIN_READY: irq_n_d = ready_n_q;
            // RQ7: comparator on pin
            PTSR_PIN_COMP:  irq_n_d = comp_q;
            // RQ8: wake-up on pin
            PTSR_PIN_WAKE:  irq_n_d = wake_n;
            // RQ9: all functions off
            default:        irq_n_d = 1'b1;
        endcase
    end

    // Registered so the pin never glitches while the mode field changes.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rvalid_out              = rvalid_q;
    assign reg_rdata_out               = rdata_q;
    assign threshold_low_out           = thr_low_q;
    assign conversion_power_select_out = power_q;
    assign proximity_data_out          = snap_bus.vis_prox;
    assign frequency_count_out         = snap_bus.vis_freq;
    assign interrupt_out_n             = irq_n_q;
endmodule

// file: src/ptsr_map.svh
// Register offsets, field positions and reset values of the threshold and status slice.
`ifndef PTSR_MAP_SVH
`define PTSR_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PTSR_OFS_THR_LOW_LO    8'h08
`define PTSR_OFS_THR_LOW_HI    8'h09
`define PTSR_OFS_PIN_FUNC      8'h0a
`define PTSR_OFS_POWER         8'h0b
`define PTSR_OFS_STATUS        8'h20
`define PTSR_OFS_RESULT_LO     8'h21

// ************************************************************
// Field positions and codes
// ************************************************************
`define PTSR_PIN_MODE_MSB      2
`define PTSR_PIN_MODE_OFF      3'h0
`define PTSR_PIN_MODE_WAKE     3'h1
`define PTSR_PIN_MODE_COMP     3'h2
`define PTSR_PIN_MODE_READY    3'h4
`define PTSR_POWER_BIT         0
`define PTSR_STAT_OSC_BIT      7
`define PTSR_STAT_READY_BIT    6
`define PTSR_STAT_WAKE_BIT     5
`define PTSR_STAT_COMP_BIT     4

// ************************************************************
// Reset values
// ************************************************************
`define PTSR_RST_THR_LOW       16'h0000
`define PTSR_RST_BYTE          8'h00
`define PTSR_RST_PIN_MODE      3'h0
`define PTSR_RST_POWER         1'b0
`define PTSR_RST_COMP          1'b1
`define PTSR_READ_ZERO         8'h00

`endif

// file: src/ptsr_pkg.sv
// Types shared by the threshold and status slice.
package ptsr_pkg;
    typedef logic [7:0]  ptsr_byte_t;
    typedef logic [15:0] ptsr_word_t;
    typedef logic [23:0] ptsr_freq_t;
    typedef logic [2:0]  ptsr_mode_t;

    typedef enum logic [1:0] {
        PTSR_PIN_OFF,
        PTSR_PIN_WAKE,
        PTSR_PIN_COMP,
        PTSR_PIN_READY
    } ptsr_pin_fn_e;
endpackage

// file: src/ptsr_snap_if.sv
// Interface between the register slice and its conversion snapshot store.
`timescale 1ns/1ps
interface ptsr_snap_if;
    import ptsr_pkg::*;
    logic       capture;
    ptsr_word_t capture_prox;
    ptsr_freq_t capture_freq;
    logic       load;
    ptsr_word_t pend_prox;
    ptsr_word_t vis_prox;
    ptsr_freq_t vis_freq;

    modport regs (
        output capture,
        output capture_prox,
        output capture_freq,
        output load,
        input  pend_prox,
        input  vis_prox,
        input  vis_freq
    );

    modport store (
        input  capture,
        input  capture_prox,
        input  capture_freq,
        input  load,
        output pend_prox,
        output vis_prox,
        output vis_freq
    );
endinterface

// file: src/ptsr_snapshot.sv
// Pending and visible copies of one conversion result.
`timescale 1ns/1ps
module ptsr_snapshot (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    ptsr_snap_if.store snap
);
    import ptsr_pkg::*;

    ptsr_word_t pend_prox_q;
    ptsr_freq_t pend_freq_q;
    ptsr_word_t vis_prox_q;
    ptsr_freq_t vis_freq_q;

    // ************************************************************
    // Pending conversion
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_prox_q <= 16'h0000;
            pend_freq_q <= 24'h000000;
        end else if (snap.capture) begin
            pend_prox_q <= snap.capture_prox;
            pend_freq_q <= snap.capture_freq;
        end
    end

    // ************************************************************
    // Visible copy
    // ************************************************************
    // Transfer on read start so every byte shown belongs to one conversion.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vis_prox_q <= 16'h0000;
            vis_freq_q <= 24'h000000;
        end else if (snap.load) begin
            vis_prox_q <= pend_prox_q;
            vis_freq_q <= pend_freq_q;
        end
    end

    assign snap.pend_prox = pend_prox_q;
    assign snap.vis_prox  = vis_prox_q;
    assign snap.vis_freq  = vis_freq_q;
endmodule

// file: bench/ptsr_regs_chk.sv
// Port-level assertions for the threshold and status register slice.
`timescale 1ns/1ps
module ptsr_regs_chk (
    input wire logic                 clk_in,
    input wire logic                 rst_n_in,
    input wire logic [7:0]           reg_addr_in,
    input wire logic                 reg_wr_in,
    input wire ptsr_pkg::ptsr_byte_t reg_wdata_in,
    input wire logic                 reg_rd_in,
    input wire logic                 reg_rvalid_out,
    input wire ptsr_pkg::ptsr_byte_t reg_rdata_out,
    input wire logic                 result_valid_in,
    input wire ptsr_pkg::ptsr_word_t result_prox_in,
    input wire ptsr_pkg::ptsr_freq_t result_freq_in,
    input wire ptsr_pkg::ptsr_word_t threshold_high_in,
    input wire logic                 oscillator_stopped_in,
    input wire ptsr_pkg::ptsr_word_t threshold_low_out,
    input wire logic                 conversion_power_select_out,
    input wire ptsr_pkg::ptsr_word_t proximity_data_out,
    input wire ptsr_pkg::ptsr_freq_t frequency_count_out,
    input wire logic                 interrupt_out_n
);
    import ptsr_pkg::*;
    ptsr_byte_t lo_buf_q;
    ptsr_mode_t mode_q;
    // Shadows rebuilt from bus writes alone, so a lost buffer byte in the design shows up.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lo_buf_q <= 8'h00;
            mode_q <= 3'h0;
        end else if (reg_wr_in) begin
            lo_buf_q <= (reg_addr_in == 8'h08) ? reg_wdata_in : lo_buf_q;
            mode_q <= (reg_addr_in == 8'h0a) ? reg_wdata_in[2:0] : mode_q;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_lo_buffer;
        reg_wr_in && reg_addr_in != 8'h09 |=> $stable(threshold_low_out);
    endproperty
    a_lo_buffer: assert property (p_lo_buffer) else $error("Low threshold moved without commit.");
    property p_lo_commit;
        reg_wr_in && reg_addr_in == 8'h09 |=> threshold_low_out == {$past(reg_wdata_in), $past(lo_buf_q)};
    endproperty
    a_lo_commit: assert property (p_lo_commit) else $error("Low threshold commit wrong.");
    property p_lo_read;
        reg_rd_in && reg_addr_in == 8'h08 |=> reg_rvalid_out &&
            {8'h00, reg_rdata_out} == ($past(threshold_low_out) & 16'h00ff);
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("Low byte read wrong.");
    property p_hi_read;
        reg_rd_in && reg_addr_in == 8'h09 |=> reg_rvalid_out &&
            {reg_rdata_out, 8'h00} == ($past(threshold_low_out) & 16'hff00);
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("High byte read wrong.");
    property p_power;
        reg_wr_in && reg_addr_in == 8'h0b |=> {7'h00, conversion_power_select_out} == ($past(reg_wdata_in) & 8'h01);
    endproperty
    a_power: assert property (p_power) else $error("Power bit wrong.");
    property p_ready_pin;
        mode_q == 3'h4 && !reg_wr_in && result_valid_in && conversion_power_select_out |-> ##2 !interrupt_out_n;
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("Pin missed data ready.");
    property p_pin_quiet;
        !(mode_q inside {3'h1, 3'h2, 3'h4}) && !($past(mode_q) inside {3'h1, 3'h2, 3'h4}) |-> interrupt_out_n;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("Pin active while disabled.");
    property p_result_hold;
        !(reg_rd_in && reg_addr_in == 8'h21) |=> $stable(proximity_data_out) && $stable(frequency_count_out);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("Result changed without read.");
endmodule

// file: bench/ptsr_host_model.sv
// Host side of the register port: one write or read per call, a cycle apart.
`timescale 1ns/1ps
module ptsr_host_model (
    input  wire logic                 clk_in,
    output logic [7:0]                reg_addr_out,
    output logic                      reg_wr_out,
    output ptsr_pkg::ptsr_byte_t      reg_wdata_out,
    output logic                      reg_rd_out,
    input  wire logic                 reg_rvalid_in,
    input  wire ptsr_pkg::ptsr_byte_t reg_rdata_in
);
    import ptsr_pkg::*;
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    // Released lines are inverted so a stale value can never look valid.
    task automatic wr(input logic [7:0] a, input ptsr_byte_t d);
        @(posedge clk_in);
        #1;
        {reg_addr_out, reg_wdata_out, reg_wr_out} = {a, d, 1'b1};
        @(posedge clk_in);
        #1;
        {reg_addr_out, reg_wdata_out, reg_wr_out} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output ptsr_byte_t d);
        @(posedge clk_in);
        #1;
        {reg_addr_out, reg_rd_out} = {a, 1'b1};
        @(posedge clk_in);
        #1;
        {reg_addr_out, reg_rd_out} = {~a, 1'b0};
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the threshold and status register slice.
`timescale 1ns/1ps
module tb;
    import ptsr_pkg::*;
    typedef struct {
        logic [7:0] addr;
        ptsr_byte_t data;
        ptsr_byte_t expd;
    } ptsr_row_s;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       rvalid;
    ptsr_byte_t wdata;
    ptsr_byte_t rdata;
    ptsr_byte_t got;
    logic       res_v = 1'b0;
    ptsr_word_t res_p = 16'h0000;
    ptsr_freq_t res_f = 24'h000000;
    // The high threshold is committed outside this slice; it is held steady here.
    // buffered update
    ptsr_word_t thr_hi = 16'h8000;
    logic       osc = 1'b0;
    ptsr_word_t thr_lo;
    logic       pwr;
    ptsr_word_t prox;
    ptsr_freq_t freq;
    logic       irq_n;
    int         n_errors = 0;
    int         check_count = 0;
    ptsr_row_s  rows [7] = '{'{8'h0a, 8'hf8, 8'h00}, '{8'h0b, 8'hfe, 8'h00}, '{8'h30, 8'haa, 8'h00},
        '{8'h08, 8'h12, 8'h00}, '{8'h09, 8'h34, 8'h34}, '{8'h0b, 8'h01, 8'h01}, '{8'h0a, 8'h04, 8'h04}};
    always #4 clk_in = ~clk_in;
    ptsr_host_model host_u (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
        .reg_rd_out(rd), .reg_rvalid_in(rvalid), .reg_rdata_in(rdata));
    ptsr_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rvalid_out(rvalid), .reg_rdata_out(rdata),
        .result_valid_in(res_v), .result_prox_in(res_p), .result_freq_in(res_f), .threshold_high_in(thr_hi),
        .oscillator_stopped_in(osc), .threshold_low_out(thr_lo), .conversion_power_select_out(pwr),
        .proximity_data_out(prox), .frequency_count_out(freq), .interrupt_out_n(irq_n));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] expd);
        check_count++;
        if (seen !== expd) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input ptsr_byte_t e);
        host_u.rd(a, got);
        check($sformatf("read %h", a), 24'(got), 24'(e));
    endtask
    // Returns one cycle after the taking edge, when the pin has caught up.
    task automatic send(input ptsr_word_t p);
        @(posedge clk_in);
        #1;
        {res_v, res_p, res_f} = {1'b1, p, 8'h5a, p};
        @(posedge clk_in);
        #1;
        {res_v, res_p} = {1'b0, ~p};
        @(posedge clk_in);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        rdchk(8'h20, 8'h70);
        check("power", 24'(pwr), 24'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            host_u.wr(rows[i].addr, rows[i].data);
            rdchk(rows[i].addr, rows[i].expd);
        end
        rdchk(8'h08, 8'h12);
        check("low threshold", 24'(thr_lo), 24'h3412);
        $display("test table done");
        send(16'h1234);
        check("pin", 24'(irq_n), 24'h0);
        rdchk(8'h20, 8'h30);
        rdchk(8'h21, 8'h34);
        check("visible data", 24'(prox), 24'h1234);
        check("visible count", freq, 24'h5a1234);
        host_u.wr(8'h21, 8'hff);
        host_u.wr(8'h20, 8'h00);
        rdchk(8'h21, 8'h34);
        rdchk(8'h20, 8'h70);
        check("pin", 24'(irq_n), 24'h1);
        $display("test ready done");
        host_u.wr(8'h0a, 8'h02);
        send(16'h9000);
        check("pin", 24'(irq_n), 24'h0);
        send(16'h5000);
        check("pin", 24'(irq_n), 24'h0);
        send(16'h0100);
        check("pin", 24'(irq_n), 24'h1);
        $display("test comparator done");
        host_u.wr(8'h0a, 8'h01);
        send(16'h9000);
        check("pin", 24'(irq_n), 24'h0);
        rdchk(8'h20, 8'h00);
        rdchk(8'h21, 8'h00);
        $display("test wake done");
        osc = 1'b1;
        host_u.wr(8'h0b, 8'h00);
        send(16'h0100);
        rdchk(8'h20, 8'hc0);
        host_u.wr(8'h0a, 8'h03);
        rdchk(8'h0a, 8'h03);
        check("pin", 24'(irq_n), 24'h1);
        $display("test standby done");
        @(posedge clk_in);
        #1;
        rst_n_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        rdchk(8'h09, 8'h00);
        rdchk(8'h20, 8'hf0);
        $display("test second reset done");
        stop_test();
    end
    // About ninety cycles are needed; this leaves ample margin.
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
bind ptsr_regs ptsr_regs_chk chk_u (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .reg_rvalid_out, .reg_rdata_out, .result_valid_in, .result_prox_in, .result_freq_in, .threshold_high_in,
    .oscillator_stopped_in, .threshold_low_out, .conversion_power_select_out, .proximity_data_out,
    .frequency_count_out, .interrupt_out_n);
